// ---- bench/dspg_core_props.sv ----
/*
 * Port checker for dspg_core, attached by the bind after the module.
 * Assumes one clock domain with its asynchronous active-low reset.
 */
`timescale 1ns/1ps
module dspg_core_props (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 page_wr,
  input wire logic [9:0]           page_wdata,
  input wire logic                 upd_valid,
  input wire dspg_pkg::dspg_mode_e upd_mode,
  input wire logic                 upd_ext,
  input wire logic [15:0]          upd_old_ea,
  input wire logic                 upd_overflow,
  input wire logic                 upd_underflow,
  input wire logic                 upd_stackref,
  input wire logic                 push_req,
  input wire dspg_pkg::dspg_push_e push_kind,
  input wire logic [22:0]          push_pc,
  input wire logic                 pop_req,
  input wire logic                 stack_busy,
  input wire logic [9:0]           read_page_register,
  input wire logic [15:0]          effective_addr,
  input wire logic                 addr_error_trap,
  input wire logic [15:0]          stack_pointer_reg,
  input wire logic                 mem_wr,
  input wire logic                 mem_rd,
  input wire logic [15:0]          mem_addr,
  input wire logic [15:0]          mem_wdata
);
  // A page write lands before an update of the same cycle, so judge by this value.
  logic [9:0] pg;
  assign pg = page_wr ? page_wdata : read_page_register;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_call_req;
    push_req && !stack_busy && push_kind == dspg_pkg::DSPG_PUSH_CALL;
  endsequence
  sequence s_call_words;
    mem_wr ##1 mem_wr && mem_wdata == {9'h000, $past(push_pc[22:16], 2)};
  endsequence
  a_reset_values: assert property ($rose(reset_n) |-> read_page_register == 10'h001
    && stack_pointer_reg == 16'h1000) else $error("reset value wrong");
  a_sp_aligned: assert property (stack_pointer_reg[0] == 1'b0) else $error("sp odd");
  a_push_low: assert property (push_req && !stack_busy |=> mem_wr
    && mem_addr == $past(stack_pointer_reg)
    && stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002) else $error("push wrong");
  a_call_high: assert property (s_call_req |=> s_call_words) else $error("call hi wrong");
  a_pop_read: assert property (pop_req && !push_req && !stack_busy |=> mem_rd
    && mem_addr == $past(stack_pointer_reg) - 16'h0002) else $error("pop addr wrong");
  a_trap_page0: assert property (upd_valid && upd_ext && upd_old_ea[15] && pg == 10'h000
    |=> addr_error_trap) else $error("no trap");
  a_stack_unpaged: assert property (upd_valid && upd_stackref
    |=> read_page_register == $past(pg)) else $error("stack paged");
  a_wrap_in_page: assert property (upd_valid && upd_mode != dspg_pkg::DSPG_MODE_PREPOST
    && (upd_overflow || upd_underflow) && upd_old_ea[15] && !upd_stackref
    |=> read_page_register == $past(pg) && effective_addr[15]) else $error("wrap wrong");
endmodule
bind dspg_core dspg_core_props chk (.*);

// ---- bench/dspg_core_tb.sv ----
/*
 * Bench for dspg_core: page boundary table, random updates, stack traffic.
 * Assumes the memory model answers stack reads in the same cycle.
 */
`timescale 1ns/1ps
module dspg_core_tb;
  logic        clk = 1'b0, reset_n = 1'b0, page_wr = 1'b0, upd_valid = 1'b0, upd_read = 1'b1;
  logic        upd_ext = 1'b1, upd_overflow = 1'b0, upd_underflow = 1'b0, upd_stackref = 1'b0;
  logic        sp_wr = 1'b0, push_req = 1'b0, pop_req = 1'b0, pop_pc = 1'b0, stack_busy;
  logic        rd_prog_space, rd_valid, addr_error_trap, mem_wr, mem_rd, pop_valid;
  logic [9:0]  page_wdata = 10'h000, read_page_register;
  logic [15:0] upd_old_ea = 16'h0000, upd_new_ea = 16'h0000, sp_wdata = 16'h0000;
  logic [15:0] push_data = 16'h0000, pop_rdata, effective_addr, stack_pointer_reg, exp_sp;
  logic [15:0] mem_addr, mem_wdata, pop_data, got_q[$], stk_q[$];
  logic [22:0] push_pc = 23'h00_0000;
  logic [7:0]  status_low_byte = 8'h00;
  logic [23:0] rd_addr;
  logic [14:0] c;
  int          mismatches = 0, comparisons = 0;
  dspg_pkg::dspg_mode_e upd_mode = dspg_pkg::DSPG_MODE_PREPOST;
  dspg_pkg::dspg_push_e push_kind = dspg_pkg::DSPG_PUSH_DATA;
  // Each case: page, mode, overflow, underflow, old address in the upper half.
  logic [14:0] cases [12] = '{{10'h2FF, 5'h05}, {10'h3FF, 5'h05}, {10'h001, 5'h03},
    {10'h200, 5'h03}, {10'h300, 5'h03}, {10'h150, 5'h05}, {10'h150, 5'h03}, {10'h250, 5'h0D},
    {10'h250, 5'h13}, {10'h250, 5'h1D}, {10'h150, 5'h00}, {10'h000, 5'h01}};
  dspg_core dut (.*);
  dspg_mem_model mem (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (pop_valid) begin
      got_q.push_back(pop_data);
    end
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [10:0] exp_pg(input logic [14:0] k);
    if (!k[0] || k[4:3] != 2'h0 || k[2:1] == 2'h0) return {k[14:5], k[0]};
    if (k[2] && k[14:5] == 10'h3FF) return {k[14:5], 1'b0};
    if (k[1] && (k[14:5] == 10'h001 || k[14:5] == 10'h200)) return {k[14:5], 1'b0};
    return {k[2] ? k[14:5] + 10'h001 : k[14:5] - 10'h001, 1'b1};
  endfunction
  task automatic upd(input logic [14:0] k);
    logic [10:0] e;
    logic [14:0] lo;
    e = exp_pg(k);
    lo = 15'($urandom);
    @(negedge clk);
    {page_wr, upd_valid, page_wdata, upd_overflow, upd_underflow} = {2'h3, k[14:5], k[2:1]};
    upd_mode = dspg_pkg::dspg_mode_e'(k[4:3]);
    upd_read = 1'($urandom);
    upd_old_ea = {k[0], lo};
    upd_new_ea = {k[0] & ~(k[2] | k[1]), lo};
    @(negedge clk);
    {page_wr, upd_valid} = 2'h0;
    chk(read_page_register, e[10:1]);
    chk(effective_addr, {e[0], lo});
    chk(addr_error_trap, k[14:5] == 10'h000 && k[0]);
    chk(rd_valid, !(k[14:5] == 10'h000 && k[0]) && (!e[0] || upd_read || !e[10]));
    if (e[0] && k[14:5] != 10'h000) begin
      chk(rd_addr, {e[9:1], lo});
      chk(rd_prog_space, e[10] && upd_read);
    end else if (!e[0]) begin
      chk(rd_addr, {9'h000, lo});
    end
  endtask
  task automatic stack_op(input logic psh, input dspg_pkg::dspg_push_e k, input logic two);
    @(negedge clk);
    {push_req, pop_req, pop_pc, push_pc} = {psh, !psh, two, 23'($urandom)};
    push_kind = k;
    {push_data, status_low_byte} = 24'($urandom);
    if (psh) begin
      stk_q.push_back(k == dspg_pkg::DSPG_PUSH_DATA ? push_data : push_pc[15:0]);
      if (k != dspg_pkg::DSPG_PUSH_DATA) begin
        stk_q.push_back({k == dspg_pkg::DSPG_PUSH_EXC ? status_low_byte : 8'h00, 1'b0,
          push_pc[22:16]});
      end
    end
    @(negedge clk);
    {push_req, pop_req} = 2'h0;
    for (int n = 0; n < 20 && stack_busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
    repeat ((psh && k == dspg_pkg::DSPG_PUSH_DATA) || (!psh && !two) ? 1 : 2) begin
      exp_sp = psh ? exp_sp + 16'h0002 : exp_sp - 16'h0002;
      if (!psh) chk(got_q.pop_front(), stk_q.pop_back());
    end
    chk(stack_pointer_reg, exp_sp);
  endtask
  initial begin
    void'($urandom(32'h0000_489e));
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    chk(read_page_register, 10'h001);
    chk(stack_pointer_reg, 16'h1000);
    foreach (cases[i]) upd(cases[i]);
    repeat (40) begin
      c = {10'($urandom_range(1023, 1)), 5'($urandom)};
      c[2:1] = 2'($urandom_range(2, 0));
      upd(c);
    end
    @(negedge clk);
    {page_wr, upd_valid, upd_stackref, upd_overflow, page_wdata} = {4'hF, 10'h150};
    @(negedge clk);
    {page_wr, upd_valid, upd_stackref, upd_overflow} = 4'h0;
    chk(read_page_register, 10'h150);
    chk(rd_addr, {8'h00, upd_new_ea});
    {sp_wr, sp_wdata} = {1'b1, 16'h2345};
    @(negedge clk);
    sp_wr = 1'b0;
    exp_sp = 16'h2344;
    chk(stack_pointer_reg, exp_sp);
    for (int i = 0; i < 3; i++) stack_op(1'b1, dspg_pkg::dspg_push_e'(i), 1'b0);
    for (int i = 2; i >= 0; i--) stack_op(1'b0, dspg_pkg::DSPG_PUSH_DATA, i != 0);
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    chk(read_page_register, 10'h001);
    chk(stack_pointer_reg, 16'h1000);
    final_report();
  end
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule

// ---- bench/dspg_mem_model.sv ----
/*
 * Stack memory on the far side: stores pushed words, answers reads at once.
 * Assumes word-aligned stack addresses from the block.
 */
`timescale 1ns/1ps
module dspg_mem_model (
  input wire logic        clk,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0]     pop_rdata
);
  logic [15:0] ram [32768];
  logic [15:0] last = 16'h5a5a;
  // Outside a read the bus shows the inverse of the last word, never a stale copy.
  always_comb pop_rdata = mem_rd ? ram[mem_addr[15:1]] : ~last;
  always @(posedge clk) begin
    if (mem_wr) begin
      ram[mem_addr[15:1]] <= mem_wdata;
    end
    if (mem_rd) begin
      last <= pop_rdata;
    end
  end
endmodule

// ---- inc/dspg_map.svh ----
/*
 * Constants for the data-space paging and software stack block.
 * Assumes inclusion by bare name from the design file.
 */
// Functional notes
// R01 - Page bit 9 and address bit 15 set give page<8:0> above address<14:0>.
// R02 - Program space reachable only with page at 0x200 or above, reads only.
// R03 - Boundary crossing counts only from a paged address with pre/post-modify.
// R04 - Overflow normally increments page and keeps address bit 15 set.
// R05 - Underflow normally decrements page and keeps address bit 15 set.
// R06 - Offset, modulo, bit-reversed: bit 15 set, page unchanged, wrap in page.
// R07 - Increment overflow at page 0x2FF moves to 0x300, bit 15 stays set.
// R08 - Overflow at page 0x3FF keeps page, clears bit 15 into base space.
// R09 - Underflow at page 0x001 or 0x200 keeps page, clears bit 15.
// R10 - Underflow at page 0x300 moves to 0x2FF, bit 15 stays set.
// R11 - Extended access with page 0x000 raises an address error trap.
// R12 - Base addresses 0x0000 to 0x7FFF always reach page zero.
// R13 - Read page register resets to 0x001.
// R14 - Other pages reachable only via 0x8000 to 0xFFFF with the page register.
// R15 - Stack pointer bit 0 is forced to zero by hardware.
// R16 - Stack pointer resets to 0x1000.
// R17 - Stack grows upward: push writes then increments, pop decrements then reads.
// R18 - Counter push writes bits 15:0 then bits 22:16, upper byte zero for calls.
// R19 - Exception push puts status low byte beside the counter's upper part.
// R20 - Stack and active frame pointer never paged, 16-bit addresses only.
// R21 - Stack pointer auto-updated by calls, returns, exceptions; also writable.
// R22 - Read page register is 10 bits: bit 9 program space, bits 8:0 page.
`ifndef DSPG_MAP_SVH
`define DSPG_MAP_SVH
`define DSPG_PAGE_RESET  10'h001
`define DSPG_SP_RESET    16'h1000
`define DSPG_PAGE_PS_LO  10'h200
`define DSPG_PAGE_LSW_HI 10'h2FF
`define DSPG_PAGE_MSB_LO 10'h300
`define DSPG_PAGE_MSB_HI 10'h3FF
`define DSPG_PAGE_ZERO   10'h000
`define DSPG_PS_BIT      9
`define DSPG_EA_TOP      15
`define DSPG_WORD_STEP   16'h0002
`endif

// ---- inc/dspg_pkg.sv ----
/*
 * Types for the data-space paging and software stack block.
 * Assumes dspg_map.svh is on the include path.
 */
package dspg_pkg;
  typedef enum logic [1:0] {
    DSPG_MODE_PREPOST = 2'b00,
    DSPG_MODE_OFFSET  = 2'b01,
    DSPG_MODE_MODULO  = 2'b10,
    DSPG_MODE_BITREV  = 2'b11
  } dspg_mode_e;
  typedef enum logic [2:0] {
    DSPG_ST_IDLE   = 3'b000,
    DSPG_ST_PUSH_HI = 3'b001,
    DSPG_ST_POP_HI = 3'b010
  } dspg_state_e;
  typedef enum logic [1:0] {
    DSPG_PUSH_DATA = 2'b00,
    DSPG_PUSH_CALL = 2'b01,
    DSPG_PUSH_EXC  = 2'b10
  } dspg_push_e;
endpackage

// ---- rtl/dspg_core.sv ----
/*
 * Data-space page register with boundary handling and the software stack
 * pointer with its push and pop sequencer.
 * Assumes the address units present one update request per cycle with
 * same-clock signals, and that the memory side accepts one stack word a cycle.
 */
`timescale 1ns/1ps
`include "dspg_map.svh"
module dspg_core (
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Page register write and address update request.
  input  wire logic               page_wr,
  input  wire logic [9:0]         page_wdata,
  input  wire logic               upd_valid,
  input  wire dspg_pkg::dspg_mode_e upd_mode,
  input  wire logic               upd_read,
  input  wire logic               upd_ext,
  input  wire logic [15:0]        upd_old_ea,
  input  wire logic [15:0]        upd_new_ea,
  input  wire logic               upd_overflow,
  input  wire logic               upd_underflow,
  input  wire logic               upd_stackref,
  // Stack pointer requests.
  input  wire logic               sp_wr,
  input  wire logic [15:0]        sp_wdata,
  input  wire logic               push_req,
  input  wire dspg_pkg::dspg_push_e push_kind,
  input  wire logic [15:0]        push_data,
  input  wire logic [22:0]        push_pc,
  input  wire logic [7:0]         status_low_byte,
  input  wire logic               pop_req,
  input  wire logic               pop_pc,
  input  wire logic [15:0]        pop_rdata,
  // Outputs, all registered.
  output logic [9:0]              read_page_register,
  output logic [23:0]             rd_addr,
  output logic                    rd_prog_space,
  output logic                    rd_valid,
  output logic [15:0]             effective_addr,
  output logic                    addr_error_trap,
  output logic [15:0]             stack_pointer_reg,
  output logic                    mem_wr,
  output logic                    mem_rd,
  output logic [15:0]             mem_addr,
  output logic [15:0]             mem_wdata,
  output logic [15:0]             pop_data,
  output logic                    pop_valid,
  output logic                    stack_busy
);
  function automatic logic in_ps(input logic [9:0] pg);
    in_ps = pg >= `DSPG_PAGE_PS_LO;
  endfunction

  logic [9:0]  next_read_page_register;
  logic [23:0] next_rd_addr;
  logic        next_rd_prog_space;
  logic        next_rd_valid;
  logic [15:0] next_effective_addr;
  logic        next_addr_error_trap;
  logic        paged;
  logic        ea15;
  logic [9:0]  cur_page;

  always_comb begin
    next_read_page_register = read_page_register;
    next_effective_addr     = effective_addr;
    next_rd_addr            = rd_addr;
    next_rd_prog_space      = 1'b0;
    next_rd_valid           = 1'b0;
    next_addr_error_trap    = 1'b0;
    ea15                    = upd_new_ea[`DSPG_EA_TOP];
    // A page write in the same cycle as an update lands first, so the boundary
    // decisions below start from the freshly written page and never drop it.
    cur_page                = page_wr ? page_wdata : read_page_register;
    // Only a paged old address with pre/post modify can cross a page. [R03]
    paged = upd_old_ea[`DSPG_EA_TOP] && !upd_stackref;
    next_read_page_register = cur_page; // [R22]
    if (upd_valid) begin
      if (paged && (upd_overflow || upd_underflow)) begin
        if (upd_mode != dspg_pkg::DSPG_MODE_PREPOST) begin
          ea15 = 1'b1; // [R06]
        end else if (upd_overflow) begin
          if (cur_page == `DSPG_PAGE_MSB_HI) begin
            ea15 = 1'b0; // [R08]
          end else if (cur_page == `DSPG_PAGE_LSW_HI) begin
            next_read_page_register = `DSPG_PAGE_MSB_LO; // [R07]
            ea15 = 1'b1;
          end else begin
            next_read_page_register = cur_page + 10'h001; // [R04]
            ea15 = 1'b1;
          end
        end else begin
          if (cur_page == `DSPG_PAGE_RESET ||
              cur_page == `DSPG_PAGE_PS_LO) begin
            ea15 = 1'b0; // [R09]
          end else if (cur_page == `DSPG_PAGE_MSB_LO) begin
            next_read_page_register = `DSPG_PAGE_LSW_HI; // [R10]
            ea15 = 1'b1;
          end else begin
            next_read_page_register = cur_page - 10'h001; // [R05]
            ea15 = 1'b1;
          end
        end
      end
      next_effective_addr = {ea15, upd_new_ea[14:0]};
      // Stack and frame pointers stay in the 16-bit base space. [R20]
      if (!ea15 || upd_stackref) begin
        next_rd_addr  = {8'h00, ea15, upd_new_ea[14:0]}; // [R12]
        next_rd_valid = 1'b1;
      end else if (upd_ext && next_read_page_register == `DSPG_PAGE_ZERO) begin
        next_addr_error_trap = 1'b1; // [R11]
      end else begin
        next_rd_addr = {next_read_page_register[8:0], upd_new_ea[14:0]}; // [R01] [R14]
        // Program space only through the high pages and only for reads. [R02]
        next_rd_prog_space = next_read_page_register[`DSPG_PS_BIT] &&
                             in_ps(next_read_page_register) && upd_read;
        next_rd_valid = upd_read || !next_read_page_register[`DSPG_PS_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_page_register <= `DSPG_PAGE_RESET; // [R13]
      rd_addr            <= 24'h00_0000;
      rd_prog_space      <= 1'b0;
      rd_valid           <= 1'b0;
      effective_addr     <= 16'h0000;
      addr_error_trap    <= 1'b0;
    end else begin
      read_page_register <= next_read_page_register;
      rd_addr            <= next_rd_addr;
      rd_prog_space      <= next_rd_prog_space;
      rd_valid           <= next_rd_valid;
      effective_addr     <= next_effective_addr;
      addr_error_trap    <= next_addr_error_trap;
    end
  end

  // Stack sequencer: two-word pushes and pops take two cycles.
  dspg_pkg::dspg_state_e state;
  dspg_pkg::dspg_state_e next_state;
  logic [15:0] next_stack_pointer_reg;
  logic        next_mem_wr;
  logic        next_mem_rd;
  logic [15:0] next_mem_addr;
  logic [15:0] next_mem_wdata;
  logic [15:0] next_pop_data;
  logic        next_pop_valid;
  logic [15:0] hi_word;
  logic [15:0] next_hi_word;

  always_comb begin
    next_state             = state;
    next_stack_pointer_reg = stack_pointer_reg;
    next_mem_wr            = 1'b0;
    next_mem_rd            = 1'b0;
    next_mem_addr          = mem_addr;
    next_mem_wdata         = mem_wdata;
    next_pop_data          = pop_data;
    next_pop_valid         = 1'b0;
    next_hi_word           = hi_word;
    case (state)
      dspg_pkg::DSPG_ST_IDLE: begin
        if (push_req) begin
          // Push writes at the free word, then the pointer moves up. [R17]
          next_mem_wr            = 1'b1;
          next_mem_addr          = stack_pointer_reg;
          next_stack_pointer_reg = stack_pointer_reg + `DSPG_WORD_STEP; // [R21]
          if (push_kind == dspg_pkg::DSPG_PUSH_DATA) begin
            next_mem_wdata = push_data;
          end else begin
            next_mem_wdata = push_pc[15:0]; // [R18]
            if (push_kind == dspg_pkg::DSPG_PUSH_EXC) begin
              next_hi_word = {status_low_byte, 1'b0, push_pc[22:16]}; // [R19]
            end else begin
              next_hi_word = {8'h00, 1'b0, push_pc[22:16]}; // [R18]
            end
            next_state = dspg_pkg::DSPG_ST_PUSH_HI;
          end
        end else if (pop_req) begin
          // Pop moves the pointer down first, then reads. [R17]
          next_mem_rd            = 1'b1;
          next_mem_addr          = stack_pointer_reg - `DSPG_WORD_STEP;
          next_stack_pointer_reg = stack_pointer_reg - `DSPG_WORD_STEP; // [R21]
          if (pop_pc) begin
            next_state = dspg_pkg::DSPG_ST_POP_HI;
          end
        end else if (sp_wr) begin
          next_stack_pointer_reg = sp_wdata; // [R21]
        end
      end
      dspg_pkg::DSPG_ST_PUSH_HI: begin
        next_mem_wr            = 1'b1;
        next_mem_addr          = stack_pointer_reg;
        next_mem_wdata         = hi_word;
        next_stack_pointer_reg = stack_pointer_reg + `DSPG_WORD_STEP;
        next_state             = dspg_pkg::DSPG_ST_IDLE;
      end
      dspg_pkg::DSPG_ST_POP_HI: begin
        next_mem_rd            = 1'b1;
        next_mem_addr          = stack_pointer_reg - `DSPG_WORD_STEP;
        next_stack_pointer_reg = stack_pointer_reg - `DSPG_WORD_STEP;
        next_state             = dspg_pkg::DSPG_ST_IDLE;
      end
      default: begin
        next_state = dspg_pkg::DSPG_ST_IDLE;
      end
    endcase
    if (mem_rd) begin
      next_pop_data  = pop_rdata;
      next_pop_valid = 1'b1;
    end
    // Misaligned stack words are impossible by construction. [R15]
    next_stack_pointer_reg[0] = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state             <= dspg_pkg::DSPG_ST_IDLE;
      stack_pointer_reg <= `DSPG_SP_RESET; // [R16]
      mem_wr            <= 1'b0;
      mem_rd            <= 1'b0;
      mem_addr          <= 16'h0000;
      mem_wdata         <= 16'h0000;
      pop_data          <= 16'h0000;
      pop_valid         <= 1'b0;
      hi_word           <= 16'h0000;
      stack_busy        <= 1'b0;
    end else begin
      state             <= next_state;
      stack_pointer_reg <= next_stack_pointer_reg;
      mem_wr            <= next_mem_wr;
      mem_rd            <= next_mem_rd;
      mem_addr          <= next_mem_addr;
      mem_wdata         <= next_mem_wdata;
      pop_data          <= next_pop_data;
      pop_valid         <= next_pop_valid;
      hi_word           <= next_hi_word;
      stack_busy        <= next_state != dspg_pkg::DSPG_ST_IDLE;
    end
  end
endmodule
